// file: common/ces_map.vh
// Constants for the CPU exception sequencer: vectors, modes and timing
`ifndef CES_MAP_VH
`define CES_MAP_VH
// Minimum mode vector table byte addresses (two-byte entries)
`define CES_VEC_RESET 16'h0000
`define CES_VEC_INVALID 16'h0004
`define CES_VEC_ZDIV 16'h0006
`define CES_VEC_TRAPVS 16'h0008
`define CES_VEC_ADDRERR 16'h0010
`define CES_VEC_TRACE 16'h0012
`define CES_VEC_NMI 16'h0016
`define CES_VEC_TRAP_ALWAYS_OP 16'h0020
`define CES_VEC_EXTERNAL_INT_LINE_0 16'h0040
`define CES_VEC_EXTERNAL_INT_LINE_1 16'h0042
`define CES_VEC_INTERNAL 16'h0044
`define CES_VEC_TOP 16'h007F
// Address ranges that fault
`define CES_REGFIELD_LO 16'hFF80
`define CES_UNPOP_LO 16'h8000
`define CES_UNPOP_HI 16'hFB7F
`define CES_RAM_LO 16'hFB80
`define CES_RAM_HI 16'hFF7F
// Status word field positions
`define CES_SW_TRACE 15
`define CES_SW_MASK_HI 10
`define CES_SW_MASK_LO 8
`define CES_MASK_RESET 3'h7
// Reset pin low time expected from outside, in system clocks
`define CES_RESET_MIN_CYC 6
// Exception causes
`define CES_CAUSE_NONE 3'h0
`define CES_CAUSE_ADDR 3'h1
`define CES_CAUSE_TRACE 3'h2
`define CES_CAUSE_INT 3'h3
`define CES_CAUSE_INSN 3'h4
`define CES_CAUSE_RESET 3'h5
// Sequencer states
`define CES_ST_IDLE 4'h0
`define CES_ST_RST0 4'h1
`define CES_ST_RST1 4'h2
`define CES_ST_PUSH_PC 4'h3
`define CES_ST_PUSH_CP 4'h4
`define CES_ST_PUSH_SW 4'h5
`define CES_ST_VEC0 4'h6
`define CES_ST_VEC1 4'h7
`define CES_ST_BRANCH 4'h8
`define CES_ST_HALT 4'h9
`endif

// file: hw/ces_addr_check.v
// Address error detector for one bus cycle
`timescale 1ns/1ns
`include "ces_map.vh"
module ces_addr_check (
   bus_valid,
   bus_fetch,
   bus_word,
   bus_addr,
   single_chip,
   ram_enable,
   addr_fault
);
   input wire bus_valid;
   input wire bus_fetch;
   input wire bus_word;
   input wire [15:0] bus_addr;
   input wire single_chip;
   input wire ram_enable;
   output wire addr_fault;

   wire fetch_regfield;
   wire odd_word;
   wire unpop;
   wire ram_off;

   assign fetch_regfield = bus_fetch &&
      (bus_addr >= `CES_REGFIELD_LO);
   assign odd_word = !bus_fetch && bus_word && bus_addr[0];
   assign unpop = (bus_addr >= `CES_UNPOP_LO) &&
      (bus_addr <= `CES_UNPOP_HI);
   assign ram_off = !ram_enable && (bus_addr >= `CES_RAM_LO) &&
      (bus_addr <= `CES_RAM_HI);
   assign addr_fault = bus_valid && (fetch_regfield || odd_word ||
      (single_chip && (unpop || ram_off)));
endmodule // ces_addr_check

// file: hw/ces_seq.v
// CPU exception sequencer: priority, stacking, vector fetch, reset
// Function
// - Pending exceptions ranked reset, address error, trace, interrupt.
// - Instruction exceptions never coincide with others; no arbitration. Here an instruction exception outranks all others.
// - Reset sequence starts immediately on reset pin rising.
// - Address errors caught in bus cycles, handled at instruction end.
// - Trace exception at every instruction end while trace flag is one.
// - Interrupts sampled at instruction or sequence end, taken at end; sampled here at instruction end only.
// - Non-reset: push PC, code page (max), status; clear trace; vector.
// - Interrupt sequence loads accepted level into mask level.
// - Vector table at page 0 bottom; 2-byte or 4-byte entries.
// - Invalid, zero divide, trap-overflow vectors at 4,6,8 (doubled max).
// - Address error, trace, NMI vectors at 10,12,16 (doubled max).
// - Trap-always at 20, external lines at 40/42, internal follow.
// - Reset low halts processing and initialises state, not RAM.
// - Mode pins latched into mode bits when leaving reset.
// - Reset: no push, trace cleared, mask 7, all interrupts blocked.
// - Minimum mode reset loads PC from first word.
// - Maximum reset: byte 0 dropped, byte 1 to code page, 2-3 to PC.
// - SP untouched; first instruction runs; control load blocks again.
// - Address error clears trace flag and keeps mask level.
// - Prefetch from register field raises address error.
// - Odd-address word data access raises address error.
// - Single-chip unpopulated or disabled-RAM access raises error.
// - After control-modify or return ops, all but instruction exceptions wait one more op.
`timescale 1ns/1ns
`include "ces_map.vh"
module ces_seq (
   mclk,
   resetn,
   mode_select_pins,
   insn_end,
   insn_op_defer,
   insn_exc,
   insn_exc_vec,
   int_req,
   int_nmi,
   int_level,
   int_vec_index,
   cpu_bus_valid,
   cpu_bus_fetch,
   cpu_bus_word,
   cpu_bus_addr,
   ram_enable,
   pc_in,
   cp_in,
   sw_in,
   mem_req,
   mem_we,
   mem_addr,
   mem_wdata,
   mem_ack,
   mem_rdata,
   cpu_run,
   seq_busy,
   load_pc,
   pc_out,
   cp_out,
   sw_out,
   int_ack,
   latched_mode_bits
);
   input wire mclk;
   input wire resetn;
   input wire [2:0] mode_select_pins;
   input wire insn_end;
   input wire insn_op_defer;
   input wire insn_exc;
   input wire [6:0] insn_exc_vec;
   input wire int_req;
   input wire int_nmi;
   input wire [2:0] int_level;
   input wire [6:0] int_vec_index;
   input wire cpu_bus_valid;
   input wire cpu_bus_fetch;
   input wire cpu_bus_word;
   input wire [15:0] cpu_bus_addr;
   input wire ram_enable;
   input wire [15:0] pc_in;
   input wire [7:0] cp_in;
   input wire [15:0] sw_in;
   output reg mem_req;
   output reg mem_we;
   output reg [15:0] mem_addr;
   output reg [15:0] mem_wdata;
   input wire mem_ack;
   input wire [15:0] mem_rdata;
   output wire cpu_run;
   output wire seq_busy;
   output reg load_pc;
   output reg [15:0] pc_out;
   output reg [7:0] cp_out;
   output reg [15:0] sw_out;
   output reg int_ack;
   output reg [2:0] latched_mode_bits;

   reg [2:0] mode_sync1_reg;
   reg [2:0] mode_sync2_reg;
   reg [3:0] state_reg;
   reg [2:0] cause_reg;
   reg [6:0] vec_idx_reg;
   reg [2:0] new_mask_reg;
   reg addr_err_pend_reg;
   reg block_int_reg;
   reg [15:0] sw_save_reg;
   reg [15:0] pc_save_reg;
   reg [7:0] cp_save_reg;
   reg first_reg;
   reg rst_armed_reg;
   reg [2:0] cause_next;
   reg [6:0] vec_next;
   wire addr_fault;
   wire max_mode;
   wire [15:0] vec_base;
   wire take_ok;
   wire stall_ok;
   wire take_addr;
   // Table entry indices of the fixed vectors: byte address halved
   localparam [15:0] VIX_ADDRERR = `CES_VEC_ADDRERR >> 1;
   localparam [15:0] VIX_TRACE = `CES_VEC_TRACE >> 1;
   localparam [15:0] VIX_NMI = `CES_VEC_NMI >> 1;

   ces_addr_check u_check (
      .bus_valid(cpu_bus_valid),
      .bus_fetch(cpu_bus_fetch),
      .bus_word(cpu_bus_word),
      .bus_addr(cpu_bus_addr),
      .single_chip(latched_mode_bits == 3'h7),
      .ram_enable(ram_enable),
      .addr_fault(addr_fault)
   );

   // Mode bit 2 high selects the maximum (paged) mode
   assign max_mode = latched_mode_bits[2];
   // Entry width doubles in maximum mode
   assign vec_base = max_mode ? {7'h00, vec_idx_reg, 2'h0} :
      {8'h00, vec_idx_reg, 1'h0};
   assign seq_busy = (state_reg != `CES_ST_IDLE);
   assign cpu_run = !seq_busy;
   // Control-modify and return ops move the boundary one op further
   assign take_ok = insn_end && !insn_op_defer;
   assign stall_ok = !block_int_reg;
   assign take_addr = (state_reg == `CES_ST_IDLE) &&
      (cause_next == `CES_CAUSE_ADDR);

   // Priority among causes at an instruction boundary
   always @* begin
      cause_next = `CES_CAUSE_NONE;
      vec_next = 7'h00;
      if (insn_exc && insn_end) begin
         cause_next = `CES_CAUSE_INSN;
         vec_next = insn_exc_vec;
      end else if (take_ok) begin
         if (addr_err_pend_reg || addr_fault) begin
            cause_next = `CES_CAUSE_ADDR;
            vec_next = VIX_ADDRERR[6:0];
         end else if (sw_in[`CES_SW_TRACE]) begin
            cause_next = `CES_CAUSE_TRACE;
            vec_next = VIX_TRACE[6:0];
         end else if (int_req && stall_ok) begin
            cause_next = `CES_CAUSE_INT;
            vec_next = int_nmi ? VIX_NMI[6:0] : int_vec_index;
         end
      end
   end

   // No reset: the pins must be tracked while resetn is still low
   always @(posedge mclk) begin
      mode_sync1_reg <= mode_select_pins;
      mode_sync2_reg <= mode_sync1_reg;
   end

   // Reset low initialises all state but the mode pin synchronisers; RAM is outside this block
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= `CES_ST_HALT;
         rst_armed_reg <= 1'b1;
         cause_reg <= `CES_CAUSE_NONE;
         vec_idx_reg <= 7'h00;
         new_mask_reg <= 3'h0;
         addr_err_pend_reg <= 1'b0;
         block_int_reg <= 1'b1;
         sw_save_reg <= 16'h0000;
         pc_save_reg <= 16'h0000;
         cp_save_reg <= 8'h00;
         first_reg <= 1'b0;
         latched_mode_bits <= 3'h0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 16'h0000;
         mem_wdata <= 16'h0000;
         load_pc <= 1'b0;
         pc_out <= 16'h0000;
         cp_out <= 8'h00;
         sw_out <= 16'h0000;
         int_ack <= 1'b0;
      end else begin
         load_pc <= 1'b0;
         int_ack <= 1'b0;
         // Sticky fault; a new fault beside a taken old one stays set
         if (addr_fault && (addr_err_pend_reg || !take_addr))
            addr_err_pend_reg <= 1'b1;
         else if (take_addr)
            addr_err_pend_reg <= 1'b0;
         if (insn_end && state_reg == `CES_ST_IDLE && first_reg) begin
            // First op has run; later defer ops are held by take_ok
            first_reg <= 1'b0;
            block_int_reg <= 1'b0;
         end
         case (state_reg)
            `CES_ST_HALT: begin
               if (rst_armed_reg) begin
                  // First clock after release: start at once
                  rst_armed_reg <= 1'b0;
                  latched_mode_bits <= mode_sync2_reg;
                  cause_reg <= `CES_CAUSE_RESET;
                  sw_out <= 16'h0000;
                  sw_out[`CES_SW_MASK_HI:`CES_SW_MASK_LO] <=
                     `CES_MASK_RESET;
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_addr <= `CES_VEC_RESET;
                  state_reg <= `CES_ST_RST0;
               end
            end
            `CES_ST_RST0: begin
               if (mem_ack) begin
                  if (latched_mode_bits[2]) begin
                     cp_out <= mem_rdata[7:0];
                     mem_addr <= `CES_VEC_RESET + 16'h0002;
                     state_reg <= `CES_ST_RST1;
                  end else begin
                     mem_req <= 1'b0;
                     pc_out <= mem_rdata;
                     load_pc <= 1'b1;
                     first_reg <= 1'b1;
                     state_reg <= `CES_ST_IDLE;
                  end
               end
            end
            `CES_ST_RST1: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  pc_out <= mem_rdata;
                  load_pc <= 1'b1;
                  first_reg <= 1'b1;
                  state_reg <= `CES_ST_IDLE;
               end
            end
            `CES_ST_IDLE: begin
               if (cause_next != `CES_CAUSE_NONE) begin
                  cause_reg <= cause_next;
                  vec_idx_reg <= vec_next;
                  new_mask_reg <= int_nmi ? 3'h7 : int_level;
                  int_ack <= (cause_next == `CES_CAUSE_INT);
                  pc_save_reg <= pc_in;
                  cp_save_reg <= cp_in;
                  sw_save_reg <= sw_in;
                  // Stack pointer is the CPU's and never set here
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= 16'h0000;
                  mem_wdata <= pc_in;
                  state_reg <= `CES_ST_PUSH_PC;
               end
            end
            `CES_ST_PUSH_PC: begin
               if (mem_ack) begin
                  if (max_mode) begin
                     mem_wdata <= {8'h00, cp_save_reg};
                     state_reg <= `CES_ST_PUSH_CP;
                  end else begin
                     mem_wdata <= sw_save_reg;
                     state_reg <= `CES_ST_PUSH_SW;
                  end
               end
            end
            `CES_ST_PUSH_CP: begin
               if (mem_ack) begin
                  mem_wdata <= sw_save_reg;
                  state_reg <= `CES_ST_PUSH_SW;
               end
            end
            `CES_ST_PUSH_SW: begin
               if (mem_ack) begin
                  sw_out <= sw_save_reg;
                  sw_out[`CES_SW_TRACE] <= 1'b0;
                  if (cause_reg == `CES_CAUSE_INT)
                     sw_out[`CES_SW_MASK_HI:`CES_SW_MASK_LO] <=
                        new_mask_reg;
                  mem_we <= 1'b0;
                  mem_addr <= vec_base;
                  state_reg <= `CES_ST_VEC0;
               end
            end
            `CES_ST_VEC0: begin
               if (mem_ack) begin
                  if (max_mode) begin
                     cp_out <= mem_rdata[7:0];
                     mem_addr <= vec_base + 16'h0002;
                     state_reg <= `CES_ST_VEC1;
                  end else begin
                     mem_req <= 1'b0;
                     pc_out <= mem_rdata;
                     state_reg <= `CES_ST_BRANCH;
                  end
               end
            end
            `CES_ST_VEC1: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  pc_out <= mem_rdata;
                  state_reg <= `CES_ST_BRANCH;
               end
            end
            `CES_ST_BRANCH: begin
               load_pc <= 1'b1;
               cause_reg <= `CES_CAUSE_NONE;
               state_reg <= `CES_ST_IDLE;
            end
            default: begin
               state_reg <= `CES_ST_IDLE;
            end
         endcase
      end
   end
endmodule // ces_seq

// file: test/ces_seq_assertions.sv
// Port checks for the exception sequencer
`timescale 1ns/1ns
module ces_seq_assertions (
   input wire mclk,
   input wire resetn,
   input wire insn_end,
   input wire insn_exc,
   input wire mem_req,
   input wire mem_we,
   input wire [15:0] mem_addr,
   input wire mem_ack,
   input wire cpu_run,
   input wire seq_busy,
   input wire load_pc,
   input wire [15:0] sw_out,
   input wire int_ack,
   input wire [2:0] latched_mode_bits
);
   reg [1:0] age_reg;
   reg rst_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Age counter keeps the mode check clear of the latch edge
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         age_reg <= 2'h0;
         rst_reg <= 1'b1;
      end else begin
         if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
         if (load_pc) rst_reg <= 1'b0;
      end
   end
   sequence s_take;
      insn_end && insn_exc && !seq_busy;
   endsequence
   sequence s_push;
      mem_req && mem_we;
   endsequence
   AST_RST_FETCH: assert property (
      $rose(resetn) |=> mem_req && !mem_we && mem_addr == 16'h0000)
      else $error("reset fetch missing");
   AST_RST_BOUND: assert property (
      $rose(resetn) |-> ##[1:60] load_pc)
      else $error("reset load late");
   AST_RST_MASK: assert property (
      rst_reg && load_pc |-> sw_out[10:8] == 3'h7 && !sw_out[15])
      else $error("reset status wrong");
   AST_RST_NOPUSH: assert property (
      rst_reg |-> !(mem_req && mem_we))
      else $error("push during reset");
   AST_MODE_HOLD: assert property (
      age_reg == 2'h3 |-> $stable(latched_mode_bits))
      else $error("mode bits moved");
   AST_TRACE_CLR: assert property (
      load_pc |-> !sw_out[15])
      else $error("trace flag left set");
   AST_EXC_PUSH: assert property (
      s_take |-> ##[1:40] s_push)
      else $error("no context push");
   AST_REQ_HOLD: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("request dropped early");
   AST_RUN_BUSY: assert property (
      cpu_run != seq_busy)
      else $error("run and busy agree");
   AST_IDLE_QUIET: assert property (
      !seq_busy |-> !mem_req)
      else $error("bus request when idle");
   AST_PULSES: assert property (
      load_pc || int_ack |=> !load_pc && !int_ack)
      else $error("pulse too long");
endmodule // ces_seq_assertions
bind ces_seq ces_seq_assertions u_ces_seq_assertions (.mclk(mclk),
   .resetn(resetn), .insn_end(insn_end), .insn_exc(insn_exc),
   .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_ack(mem_ack), .cpu_run(cpu_run), .seq_busy(seq_busy),
   .load_pc(load_pc), .sw_out(sw_out), .int_ack(int_ack),
   .latched_mode_bits(latched_mode_bits));

// file: test/ces_mem_model.sv
// Memory model holding the exception vector table
`timescale 1ns/1ns
module ces_mem_model (
   input wire mclk,
   input wire resetn,
   input wire [2:0] wait_cycles,
   input wire mem_req,
   input wire mem_we,
   input wire [15:0] mem_addr,
   output reg mem_ack,
   output reg [15:0] mem_rdata
);
   reg [2:0] cnt_reg;
   // Contents arbitrary but unique per entry; writes are not stored
   function [15:0] vec_word(input [15:0] a);
      vec_word = {a[7:0] ^ 8'h3C, a[7:0] ^ 8'h81};
   endfunction
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mem_ack <= 1'b0;
         cnt_reg <= 3'h0;
         mem_rdata <= 16'h5A5A;
      end else if (mem_req && !mem_ack && cnt_reg == wait_cycles) begin
         mem_ack <= 1'b1;
         cnt_reg <= 3'h0;
         mem_rdata <= mem_we ? ~mem_rdata : vec_word(mem_addr);
      end else begin
         mem_ack <= 1'b0;
         if (mem_req && !mem_ack) cnt_reg <= cnt_reg + 3'h1;
         // Data only good with ack, so scramble it otherwise
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule // ces_mem_model

// file: test/test_ces_seq.sv
// Self-checking bench for the exception sequencer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
   end \
end
module test_ces_seq;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] mode_select_pins = 3'h1;
   logic insn_end = 1'b0;
   logic insn_op_defer = 1'b0;
   logic insn_exc = 1'b0;
   logic [6:0] insn_exc_vec = 7'h00;
   logic int_req = 1'b0;
   logic int_nmi = 1'b0;
   logic [2:0] int_level = 3'h5;
   logic [6:0] int_vec_index = 7'h20;
   logic cpu_bus_valid = 1'b0;
   logic cpu_bus_fetch = 1'b0;
   logic cpu_bus_word = 1'b0;
   logic [15:0] cpu_bus_addr = 16'h0000;
   logic [15:0] pc_in = 16'h1234;
   logic [7:0] cp_in = 8'h5C;
   logic [15:0] sw_in = 16'h0300;
   logic [2:0] wait_cycles = 3'h0;
   logic ram_enable = 1'b1;
   wire mem_req, mem_we, mem_ack, cpu_run, seq_busy, load_pc, int_ack;
   wire [15:0] mem_addr, mem_wdata, mem_rdata, pc_out, sw_out;
   wire [7:0] cp_out;
   wire [2:0] latched_mode_bits;
   int errors = 0;
   int tests_run = 0;
   logic [15:0] wq[$];
   logic ack_seen;
   logic [15:0] got_pc, got_sw;
   logic [7:0] got_cp;
   ces_seq u_ces_seq (.mclk(mclk), .resetn(resetn),
      .mode_select_pins(mode_select_pins), .insn_end(insn_end),
      .insn_op_defer(insn_op_defer), .insn_exc(insn_exc),
      .insn_exc_vec(insn_exc_vec), .int_req(int_req), .int_nmi(int_nmi),
      .int_level(int_level), .int_vec_index(int_vec_index),
      .cpu_bus_valid(cpu_bus_valid), .cpu_bus_fetch(cpu_bus_fetch),
      .cpu_bus_word(cpu_bus_word), .cpu_bus_addr(cpu_bus_addr),
      .ram_enable(ram_enable), .pc_in(pc_in), .cp_in(cp_in), .sw_in(sw_in),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .cpu_run(cpu_run), .seq_busy(seq_busy), .load_pc(load_pc),
      .pc_out(pc_out), .cp_out(cp_out), .sw_out(sw_out),
      .int_ack(int_ack), .latched_mode_bits(latched_mode_bits));
   ces_mem_model u_ces_mem_model (.mclk(mclk), .resetn(resetn),
      .wait_cycles(wait_cycles), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   always #4 mclk = ~mclk;
   // Sample after the edge so the design's updates have landed
   always @(posedge mclk) begin
      #1;
      if (mem_req && mem_ack && mem_we) wq.push_back(mem_wdata);
      if (int_ack) ack_seen = 1'b1;
   end
   task close_out;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task do_reset(input logic [2:0] pins);
      int i;
      @(negedge mclk);
      resetn = 1'b0;
      mode_select_pins = pins;
      for (i = 0; i < 6; i++) begin
         @(negedge mclk);
         `CHK("reset halt", 3'h1, {mem_req, cpu_run, seq_busy})
      end
      wq.delete();
      resetn = 1'b1;
   endtask
   task wait_load;
      int i;
      for (i = 0; i < 80 && load_pc !== 1'b1; i++)
         @(negedge mclk);
      if (load_pc !== 1'b1) begin
         errors++;
         close_out;
      end
      got_pc = pc_out;
      got_cp = cp_out;
      got_sw = sw_out;
      repeat (2) @(negedge mclk);
   endtask
   task chk_load(input string nm, input logic [15:0] a, input logic [2:0] m);
      wait_load;
      `CHK(nm, u_ces_mem_model.vec_word(a), got_pc)
      `CHK("status", {1'b0, m}, {got_sw[15], got_sw[10:8]})
   endtask
   task insn(input logic d, r, x, input logic [6:0] v);
      wq.delete();
      ack_seen = 1'b0;
      insn_end = 1'b1;
      insn_op_defer = d;
      int_req = r;
      insn_exc = x;
      insn_exc_vec = v;
      @(negedge mclk);
      insn_end = 1'b0;
      insn_op_defer = 1'b0;
      int_req = 1'b0;
      insn_exc = 1'b0;
   endtask
   task bus(input logic f, w, input logic [15:0] a);
      cpu_bus_valid = 1'b1;
      cpu_bus_fetch = f;
      cpu_bus_word = w;
      cpu_bus_addr = a;
      @(negedge mclk);
      cpu_bus_valid = 1'b0;
   endtask
   task sc_reset_min;
      do_reset(3'h1);
      chk_load("reset pc", 16'h0000, 3'h7);
      `CHK("mode bits", 3'h1, latched_mode_bits)
      `CHK("reset pushes", 0, wq.size())
   endtask
   task sc_defer_int;
      insn(1'b1, 1'b1, 1'b0, 7'h00);
      repeat (3) @(negedge mclk);
      `CHK("deferred", 1'b0, seq_busy)
      insn(1'b0, 1'b1, 1'b0, 7'h00);
      chk_load("irq pc", 16'h0040, 3'h5);
      `CHK("int ack", 1'b1, ack_seen)
      `CHK("push pc", pc_in, wq[0])
      `CHK("push sw", sw_in, wq[$])
   endtask
   task sc_priority;
      sw_in = 16'h8300;
      bus(1'b0, 1'b1, 16'h1235);
      `CHK("busy mid insn", 1'b0, seq_busy)
      insn(1'b0, 1'b1, 1'b0, 7'h00);
      chk_load("addr pc", 16'h0010, 3'h3);
      insn(1'b0, 1'b1, 1'b0, 7'h00);
      chk_load("trace pc", 16'h0012, 3'h3);
      sw_in = 16'h0300;
      int_nmi = 1'b1;
      int_vec_index = 7'h0B;
      insn(1'b0, 1'b1, 1'b0, 7'h00);
      chk_load("nmi pc", 16'h0016, 3'h7);
      int_nmi = 1'b0;
      bus(1'b1, 1'b0, 16'hFF80);
      insn(1'b0, 1'b0, 1'b0, 7'h00);
      chk_load("prefetch pc", 16'h0010, 3'h3);
   endtask
   task sc_insn_exc;
      logic [6:0] v[5] = '{7'h02, 7'h03, 7'h04, 7'h10, 7'h1F};
      int i;
      for (i = 0; i < 5; i++) begin
         insn(1'b0, 1'b0, 1'b1, v[i]);
         chk_load("ix", {8'h00, v[i], 1'b0}, 3'h3);
      end
   endtask
   task sc_reset_max;
      logic [15:0] w;
      wait_cycles = 3'h3;
      do_reset(3'h7);
      chk_load("max reset pc", 16'h0002, 3'h7);
      w = u_ces_mem_model.vec_word(16'h0000);
      `CHK("max reset cp", w[7:0], got_cp)
      `CHK("max mode bits", 3'h7, latched_mode_bits)
      insn(1'b0, 1'b0, 1'b0, 7'h00);
      bus(1'b0, 1'b0, 16'h8000);
      insn(1'b0, 1'b0, 1'b0, 7'h00);
      chk_load("max err pc", 16'h0022, 3'h3);
      w = u_ces_mem_model.vec_word(16'h0020);
      `CHK("max err cp", w[7:0], got_cp)
      `CHK("max pushes", 3, wq.size())
      bus(1'b0, 1'b1, 16'hFB80);
      insn(1'b0, 1'b0, 1'b0, 7'h00);
      repeat (2) @(negedge mclk);
      `CHK("ram on", 1'b0, seq_busy)
      ram_enable = 1'b0;
      bus(1'b0, 1'b1, 16'hFB80);
      insn(1'b0, 1'b0, 1'b0, 7'h00);
      chk_load("ram off pc", 16'h0022, 3'h3);
      ram_enable = 1'b1;
   endtask
   initial begin
      sc_reset_min;
      sc_defer_int;
      sc_priority;
      sc_insn_exc;
      sc_reset_max;
      close_out;
   end
endmodule // test_ces_seq
